// [rtl/mal_pkg.sv]
package mal_pkg;

  // ==========================================================
  // Register map, byte addresses on the register bus
  // ==========================================================
  localparam int unsigned AXI_AW      = 8;
  localparam logic [7:0]  OFF_CMD     = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_WORK    = 8'h08;
  localparam logic [7:0]  OFF_PTR0    = 8'h0c;
  localparam logic [7:0]  OFF_PTR1    = 8'h10;
  localparam logic [7:0]  OFF_FADDR   = 8'h14;
  localparam logic [7:0]  OFF_FDATA   = 8'h18;

  // ==========================================================
  // Field positions and reset values
  // ==========================================================
  localparam int unsigned STATUS_BUSY_BIT = 8;
  localparam int unsigned CMD_W           = 25;
  localparam int unsigned FLAGS_W         = 3;
  localparam int unsigned PTR_LIT_W       = 6;
  localparam logic [7:0]  WORK_RST        = 8'h00;
  localparam logic [15:0] PTR_RST         = 16'h0000;
  localparam logic [6:0]  FADDR_RST       = 7'h00;
  localparam logic [1:0]  RESP_OKAY       = 2'b00;
  localparam logic [1:0]  RESP_SLVERR     = 2'b10;

  // ==========================================================
  // Operations, commands, flags and engine states
  // ==========================================================
  typedef enum logic [3:0] {
    OP_NOP        = 4'b0000,
    OP_PTR_ADD    = 4'b0001,  // pointer_literal_add
    OP_IMM_AND    = 4'b0010,  // immediate_and
    OP_IMM_ADD    = 4'b0011,  // immediate_add
    OP_FILE_AND   = 4'b0100,  // file_and
    OP_FILE_ADD   = 4'b0101,  // file_add
    OP_FILE_ADDC  = 4'b0110,  // file_add_with_bit_in
    OP_SHIFT      = 4'b0111,  // signed_right_shift
    OP_BIT_RESET  = 4'b1000   // single_bit_reset
  } mal_op_t;

  // Command word: op[3:0] dest[4] idx[7:5] faddr[14:8] spare[15] lit[23:16] psel[24]
  typedef struct packed {
    logic        psel;
    logic [7:0]  lit;
    logic        spare;
    logic [6:0]  faddr;
    logic [2:0]  idx;
    logic        dest;
    mal_op_t     op;
  } mal_cmd_t;

  // Status flags: c[0] half_byte_flag[1] z[2]
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } mal_flags_t;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b10
  } mal_state_t;

endpackage : mal_pkg

// [rtl/mal_add8.sv]
// ==========================================================
// Byte adder with carry and half-byte carry out
// ==========================================================
module mal_add8 (
  input  wire logic [7:0] a,     // First operand
  input  wire logic [7:0] b,     // Second operand
  input  wire logic       cin,   // Carry in
  output logic      [7:0] sum,   // Byte sum
  output logic            cout,  // Carry out of bit 7
  output logic            hcout  // Carry out of bit 3
);

  logic [4:0] lo;
  logic [4:0] hi;

  // Two nibble adds expose the carry out of bit 3 directly
  assign lo    = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign hi    = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
  assign sum   = {hi[3:0], lo[3:0]};
  assign cout  = hi[4];
  assign hcout = lo[4];

endmodule : mal_add8

// [rtl/mal_fmem.sv]
// ==========================================================
// File register memory, one write port, registered read
// ==========================================================
module mal_fmem #(
  parameter int unsigned DEPTH = 128,  // Number of file registers
  parameter int unsigned AW    = 7,    // Address width
  parameter int unsigned DW    = 8     // Data width
) (
  input  wire logic          clk,    // Clock
  input  wire logic          we,     // Write enable
  input  wire logic [AW-1:0] waddr,  // Write address
  input  wire logic [DW-1:0] wdata,  // Write data
  input  wire logic [AW-1:0] raddr,  // Read address
  output logic      [DW-1:0] rdata   // Read data, one cycle after raddr
);

  logic [DW-1:0] mem [DEPTH];

  // Array holds no reset so that it maps onto plain RAM
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule : mal_fmem

// [rtl/mal_core.sv]
// Summary of operation
// [RL1] Pointer add sign-extends a 6-bit literal (-32..31) onto the chosen one of two 16-bit pointer pairs, no flags.
// [RL2] The pointer sum wraps modulo 65536 in both directions and never saturates.
// [RL3] Immediate AND puts working register AND 8-bit literal into the working register, changing only zero.
// [RL4] Immediate add puts working register plus 8-bit literal into the working register, changing all three flags.
// [RL5] File AND combines the working register with file register 0..127, changing only zero.
// [RL6] For file operations destination 0 sends the result to the working register and 1 back to the file register.
// [RL7] File add adds working and file register into the chosen destination, changing carry, half-byte and zero.
// [RL8] Add with carry in sums working register, file register and carry into the destination, changing all flags.
// [RL9] Signed right shift moves bits 7..1 down, keeps bit 7, puts old bit 0 in carry, changes carry and zero.
// [RL10] Bit reset clears bit 0..7 of the file register and leaves other bits and all flags alone.
// [RL11] Adds set carry from bit 7, half-byte flag from bit 3, and zero exactly when the byte result is zero.
//
// The implementer's own choices: the AXI4-Lite register port and the address map.
module mal_core
  import mal_pkg::*;
(
  input  wire logic                      SYS_CLK,        // Core clock, 100 MHz
  input  wire logic                      RST,            // Asynchronous reset, active high
  input  wire logic [mal_pkg::AXI_AW-1:0] S_AXI_AWADDR,  // Write address
  input  wire logic                      S_AXI_AWVALID,  // Write address valid
  output logic                           S_AXI_AWREADY,  // Write address ready
  input  wire logic [31:0]               S_AXI_WDATA,    // Write data
  input  wire logic [3:0]                S_AXI_WSTRB,    // Write byte lanes
  input  wire logic                      S_AXI_WVALID,   // Write data valid
  output logic                           S_AXI_WREADY,   // Write data ready
  output logic [1:0]                     S_AXI_BRESP,    // Write response
  output logic                           S_AXI_BVALID,   // Write response valid
  input  wire logic                      S_AXI_BREADY,   // Write response ready
  input  wire logic [mal_pkg::AXI_AW-1:0] S_AXI_ARADDR,  // Read address
  input  wire logic                      S_AXI_ARVALID,  // Read address valid
  output logic                           S_AXI_ARREADY,  // Read address ready
  output logic [31:0]                    S_AXI_RDATA,    // Read data
  output logic [1:0]                     S_AXI_RRESP,    // Read response
  output logic                           S_AXI_RVALID,   // Read data valid
  input  wire logic                      S_AXI_RREADY    // Read data ready
);

  import mal_pkg::*;

  // ==========================================================
  // Declarations
  // ==========================================================
  mal_state_t      state;
  mal_state_t      next_state;
  mal_cmd_t        cmd;
  mal_flags_t      flags;
  logic [7:0]      work;
  logic [15:0]     ptr0;
  logic [15:0]     ptr1;
  logic [6:0]      faddr_sw;
  logic            aw_full;
  logic            w_full;
  logic [AXI_AW-1:0] aw_addr;
  logic [31:0]     w_data;
  logic [3:0]      w_strb;
  logic            next_aw_full;
  logic            next_w_full;
  logic            next_bvalid;
  logic            next_rvalid;
  logic            aw_take;
  logic            w_take;
  logic            ar_take;
  logic            do_write;
  logic            busy;
  logic            exec;
  logic [7:0]      wr_off;
  logic [7:0]      rd_off;
  logic            wr_cmd;
  logic            wr_status;
  logic            wr_work;
  logic            wr_ptr0;
  logic            wr_ptr1;
  logic            wr_faddr;
  logic            wr_fdata;
  logic            wr_hit;
  logic            wr_refused;
  logic            rd_hit;
  logic [31:0]     rd_word;
  logic [31:0]     m_cmd;
  logic [31:0]     m_status;
  logic [31:0]     m_work;
  logic [31:0]     m_ptr0;
  logic [31:0]     m_ptr1;
  logic [31:0]     m_faddr;
  logic [31:0]     m_fdata;
  logic [7:0]      fmem_q;
  logic            fmem_we;
  logic [6:0]      fmem_waddr;
  logic [7:0]      fmem_wdata;
  logic [6:0]      fmem_raddr;
  logic            imm_op;
  logic [7:0]      add_b;
  logic            add_cin;
  logic [7:0]      add_sum;
  logic            add_c;
  logic            add_dc;
  logic [15:0]     ptr_cur;
  logic [15:0]     ptr_sum;
  logic [7:0]      res;
  logic            to_w;
  logic            to_file;
  logic            upd_c;
  logic            upd_dc;
  logic            upd_z;
  logic            new_c;
  logic            new_dc;

  // Byte-lane merge of a bus write onto the current register value
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : lane_merge

  // ==========================================================
  // Bus handshake decode
  // ==========================================================
  assign aw_take      = S_AXI_AWVALID & S_AXI_AWREADY;
  assign w_take       = S_AXI_WVALID & S_AXI_WREADY;
  assign ar_take      = S_AXI_ARVALID & S_AXI_ARREADY;
  assign do_write     = aw_full & w_full;
  assign next_aw_full = (aw_full & ~do_write) | aw_take;
  assign next_w_full  = (w_full & ~do_write) | w_take;
  assign next_bvalid  = do_write | (S_AXI_BVALID & ~S_AXI_BREADY);
  assign next_rvalid  = ar_take | (S_AXI_RVALID & ~S_AXI_RREADY);

  // Address and data may arrive in either order; each is held until both are in
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= '0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      if (aw_take) aw_addr <= S_AXI_AWADDR;
      if (w_take) w_data <= S_AXI_WDATA;
      if (w_take) w_strb <= S_AXI_WSTRB;
    end
  end

  // Ready and valid outputs are registered from their next values
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
    end else begin
      S_AXI_AWREADY <= ~next_aw_full & ~next_bvalid;
      S_AXI_WREADY  <= ~next_w_full & ~next_bvalid;
      S_AXI_BVALID  <= next_bvalid;
      S_AXI_ARREADY <= ~next_rvalid;
      S_AXI_RVALID  <= next_rvalid;
    end
  end

  // ==========================================================
  // Register decode
  // ==========================================================
  assign wr_off     = {aw_addr[7:2], 2'b00};
  assign rd_off     = {S_AXI_ARADDR[7:2], 2'b00};
  assign busy       = (state != ST_IDLE);
  assign exec       = (state == ST_EXEC);
  assign wr_hit     = (wr_off == OFF_CMD) | (wr_off == OFF_STATUS) | (wr_off == OFF_WORK) |
                      (wr_off == OFF_PTR0) | (wr_off == OFF_PTR1) | (wr_off == OFF_FADDR) |
                      (wr_off == OFF_FDATA);
  // Writes that would race the engine are refused rather than merged
  assign wr_refused = busy & (wr_off != OFF_FADDR);
  assign wr_cmd     = do_write & ~busy & (wr_off == OFF_CMD);
  assign wr_status  = do_write & ~busy & (wr_off == OFF_STATUS);
  assign wr_work    = do_write & ~busy & (wr_off == OFF_WORK);
  assign wr_ptr0    = do_write & ~busy & (wr_off == OFF_PTR0);
  assign wr_ptr1    = do_write & ~busy & (wr_off == OFF_PTR1);
  assign wr_faddr   = do_write & (wr_off == OFF_FADDR);
  assign wr_fdata   = do_write & ~busy & (wr_off == OFF_FDATA);

  assign m_cmd    = {{(32-CMD_W){1'b0}}, cmd};
  assign m_status = {23'h000000, busy, 5'h00, flags};
  assign m_work   = {24'h000000, work};
  assign m_ptr0   = {16'h0000, ptr0};
  assign m_ptr1   = {16'h0000, ptr1};
  assign m_faddr  = {25'h0000000, faddr_sw};
  assign m_fdata  = {24'h000000, fmem_q};
  assign rd_hit   = (rd_off == OFF_CMD) | (rd_off == OFF_STATUS) | (rd_off == OFF_WORK) |
                    (rd_off == OFF_PTR0) | (rd_off == OFF_PTR1) | (rd_off == OFF_FADDR) |
                    (rd_off == OFF_FDATA);
  assign rd_word  = (rd_off == OFF_CMD)    ? m_cmd    :
                    (rd_off == OFF_STATUS) ? m_status :
                    (rd_off == OFF_WORK)   ? m_work   :
                    (rd_off == OFF_PTR0)   ? m_ptr0   :
                    (rd_off == OFF_PTR1)   ? m_ptr1   :
                    (rd_off == OFF_FADDR)  ? m_faddr  :
                    (rd_off == OFF_FDATA)  ? m_fdata  : 32'h0000_0000;

  // Read data is captured on the accepting edge, the write response on the edge after both halves are in; both held until taken
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      S_AXI_BRESP <= RESP_OKAY;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= RESP_OKAY;
    end else begin
      if (do_write) S_AXI_BRESP <= (wr_hit & ~wr_refused) ? RESP_OKAY : RESP_SLVERR;
      if (ar_take) S_AXI_RDATA <= rd_word;
      if (ar_take) S_AXI_RRESP <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==========================================================
  // Operation engine
  // ==========================================================
  // Every command takes the fetch step so the file byte is ready in the execute step
  always_comb begin
    case (state)
      ST_IDLE:  next_state = wr_cmd ? ST_FETCH : ST_IDLE;
      ST_FETCH: next_state = ST_EXEC;
      ST_EXEC:  next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Operand selection for the shared adder
  assign imm_op  = (cmd.op == OP_IMM_ADD) | (cmd.op == OP_IMM_AND);
  assign add_b   = imm_op ? cmd.lit : fmem_q;
  assign add_cin = (cmd.op == OP_FILE_ADDC) & flags.c;  // [RL8]
  assign ptr_cur = cmd.psel ? ptr1 : ptr0;  // [RL1]
  // A 16-bit sum drops the carry, so the pointer wraps both ways
  assign ptr_sum = ptr_cur + {{(16-PTR_LIT_W){cmd.lit[PTR_LIT_W-1]}}, cmd.lit[PTR_LIT_W-1:0]};  // [RL1] [RL2]

  mal_add8 u_add (
    .a     (work),
    .b     (add_b),
    .cin   (add_cin),
    .sum   (add_sum),
    .cout  (add_c),
    .hcout (add_dc)
  );

  // Result and flag selection per operation
  always_comb begin
    res     = 8'h00;
    to_w    = 1'b0;
    to_file = 1'b0;
    upd_c   = 1'b0;
    upd_dc  = 1'b0;
    upd_z   = 1'b0;
    new_c   = add_c;   // [RL11]
    new_dc  = add_dc;  // [RL11]
    case (cmd.op)
      OP_IMM_AND: begin
        res   = work & cmd.lit;  // [RL3]
        to_w  = 1'b1;
        upd_z = 1'b1;
      end
      OP_IMM_ADD: begin
        res    = add_sum;  // [RL4]
        to_w   = 1'b1;
        upd_c  = 1'b1;
        upd_dc = 1'b1;
        upd_z  = 1'b1;
      end
      OP_FILE_AND: begin
        res     = work & fmem_q;  // [RL5]
        to_w    = ~cmd.dest;      // [RL6]
        to_file = cmd.dest;
        upd_z   = 1'b1;
      end
      OP_FILE_ADD, OP_FILE_ADDC: begin
        res     = add_sum;    // [RL7] [RL8]
        to_w    = ~cmd.dest;  // [RL6]
        to_file = cmd.dest;
        upd_c   = 1'b1;
        upd_dc  = 1'b1;
        upd_z   = 1'b1;
      end
      OP_SHIFT: begin
        res     = {fmem_q[7], fmem_q[7:1]};  // [RL9]
        new_c   = fmem_q[0];                 // [RL9]
        to_w    = ~cmd.dest;                 // [RL6]
        to_file = cmd.dest;
        upd_c   = 1'b1;
        upd_z   = 1'b1;
      end
      OP_BIT_RESET: begin
        res     = fmem_q & ~(8'h01 << cmd.idx);  // [RL10]
        to_file = 1'b1;
      end
      default: begin
        res = 8'h00;
      end
    endcase
  end

  // Working register, flags and pointers; bus writes only land while idle
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cmd   <= '0;
      work  <= WORK_RST;
      flags <= '0;
      ptr0  <= PTR_RST;
      ptr1  <= PTR_RST;
    end else begin
      // Size casts drop the bus bits above each register's width
      if (wr_cmd) cmd <= mal_cmd_t'(CMD_W'(lane_merge(m_cmd, w_data, w_strb)));
      if (wr_work) work <= 8'(lane_merge(m_work, w_data, w_strb));
      if (wr_status) flags <= mal_flags_t'(w_data[FLAGS_W-1:0] & {FLAGS_W{w_strb[0]}} |
                                           flags & {FLAGS_W{~w_strb[0]}});
      if (wr_ptr0) ptr0 <= 16'(lane_merge(m_ptr0, w_data, w_strb));
      if (wr_ptr1) ptr1 <= 16'(lane_merge(m_ptr1, w_data, w_strb));
      if (exec & to_w) work <= res;  // [RL6]
      if (exec & upd_c) flags.c <= new_c;
      if (exec & upd_dc) flags.dc <= new_dc;
      if (exec & upd_z) flags.z <= (res == 8'h00);  // [RL11]
      if (exec & (cmd.op == OP_PTR_ADD) & ~cmd.psel) ptr0 <= ptr_sum;  // [RL1]
      if (exec & (cmd.op == OP_PTR_ADD) & cmd.psel) ptr1 <= ptr_sum;   // [RL1]
    end
  end

  // Software file window address
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      faddr_sw <= FADDR_RST;
    end else if (wr_faddr & w_strb[0]) begin
      faddr_sw <= w_data[6:0];
    end
  end

  // ==========================================================
  // File register memory
  // ==========================================================
  assign fmem_raddr = (state == ST_FETCH) ? cmd.faddr : faddr_sw;
  assign fmem_we    = (exec & to_file) | (wr_fdata & w_strb[0]);  // [RL6]
  assign fmem_waddr = exec ? cmd.faddr : faddr_sw;
  assign fmem_wdata = exec ? res : w_data[7:0];

  mal_fmem #(
    .DEPTH (128),
    .AW    (7),
    .DW    (8)
  ) u_fmem (
    .clk   (SYS_CLK),
    .we    (fmem_we),
    .waddr (fmem_waddr),
    .wdata (fmem_wdata),
    .raddr (fmem_raddr),
    .rdata (fmem_q)
  );

endmodule : mal_core

// [tb/mal_core_sva.sv]
// ==========================================================
// Bus-side timing checks on the register interface
// ==========================================================
module mal_core_sva
  import mal_pkg::*;
(
  input wire logic        SYS_CLK,        // Core clock
  input wire logic        RST,            // Reset, active high
  input wire logic        S_AXI_AWVALID,  // Write address valid
  input wire logic        S_AXI_AWREADY,  // Write address ready
  input wire logic        S_AXI_WVALID,   // Write data valid
  input wire logic        S_AXI_WREADY,   // Write data ready
  input wire logic [1:0]  S_AXI_BRESP,    // Write response
  input wire logic        S_AXI_BVALID,   // Write response valid
  input wire logic        S_AXI_BREADY,   // Write response ready
  input wire logic        S_AXI_ARVALID,  // Read address valid
  input wire logic        S_AXI_ARREADY,  // Read address ready
  input wire logic [31:0] S_AXI_RDATA,    // Read data
  input wire logic [1:0]  S_AXI_RRESP,    // Read response
  input wire logic        S_AXI_RVALID,   // Read data valid
  input wire logic        S_AXI_RREADY    // Read data ready
);
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);

  // ==========================================================
  // Response hold, timing and codes
  // ==========================================================
  AST_B_HOLD: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP)) // Hold
    else $error("write response dropped or changed before taken");
  AST_R_HOLD: assert property (S_AXI_RVALID && !S_AXI_RREADY // Hold
    |=> S_AXI_RVALID && $stable({S_AXI_RRESP, S_AXI_RDATA}))
    else $error("read data dropped or changed before taken");
  AST_B_TWO_EDGES: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY // Latency
    |=> !S_AXI_BVALID ##1 S_AXI_BVALID) else $error("write response not two edges after take");
  AST_R_ONE_EDGE: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) // Latency
    else $error("read data not one edge after address take");
  AST_AR_BLOCKED: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY) // One read at a time
    else $error("read address accepted while data pending");
  AST_W_BLOCKED: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY) // One write at a time
    else $error("write accepted while response pending");
  AST_R_RELEASE: assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID ##1 S_AXI_ARREADY) // Reopen
    else $error("read channel not reopened after handshake");
  AST_B_CODE: assert property (S_AXI_BVALID |-> S_AXI_BRESP == RESP_OKAY || S_AXI_BRESP == RESP_SLVERR) // Codes
    else $error("illegal write response code");
  AST_R_ERR_ZERO: assert property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0) // Codes
    else $error("refused read returned nonzero data");
endmodule : mal_core_sva

bind mal_core mal_core_sva i_mal_core_sva (.SYS_CLK(SYS_CLK), .RST(RST), .S_AXI_AWVALID(S_AXI_AWVALID),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY));

// [tb/mal_core_tb.sv]
module mal_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mal_pkg::*;

  // ==========================================================
  // Bus signals and bench state
  // ==========================================================
  logic        clk, rst, awv, wv, bready, arv, rready, awrdy, wrdy, bvalid, arrdy, rvalid;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [1:0]  bq [$];
  logic [33:0] rq [$];
  logic [7:0]  w, fv;
  logic [15:0] ptr [2];
  mal_flags_t  fl;
  mal_cmd_t    cmd;
  int          n_mismatch, samples_checked;

  mal_core i_mal_core (.SYS_CLK(clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
    .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ==========================================================
  // Compare, verdict and hang cut-off
  // ==========================================================
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task automatic give_up;
    n_mismatch++;
    wrap_up();
  endtask : give_up

  // Oldest expectation is matched against each completed response
  always @(posedge clk) begin
    if (!rst && rvalid && rready) check({rresp, rdata}, rq.pop_front());
    if (!rst && bvalid && bready) check({32'h0, bresp}, {32'h0, bq.pop_front()});
  end

  // ==========================================================
  // Bus master tasks; first edge keeps a strobe from being set twice
  // ==========================================================
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    bq.push_back(er);
    awaddr <= a;
    wdata  <= d;
    // Response ready is sometimes held back until the response shows, so it must wait
    {awv, wv, bready} <= {2'b11, 1'($urandom)};
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bvalid && bready) break;
      if (bvalid) bready <= 1'b1;
    end
    bready <= 1'b0;
    if (n == 50) give_up();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clk);
    rq.push_back({er, d});
    araddr <= a;
    {arv, rready} <= {1'b1, 1'($urandom)};
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
      if (rvalid && rready) break;
      if (rvalid) rready <= 1'b1;
    end
    rready <= 1'b0;
    if (n == 50) give_up();
  endtask : rd

  // Pointers near both ends so that wrap-around is exercised often
  function automatic logic [15:0] near_edge;
    return ($urandom % 2) ? (16'hffe0 | 16'($urandom % 32)) : 16'($urandom % 32);
  endfunction : near_edge

  // ==========================================================
  // Reference behaviour of one command
  // ==========================================================
  task automatic model;
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] r;
    logic       cin;
    r   = (cmd.op == OP_IMM_ADD) ? cmd.lit : fv;
    cin = (cmd.op == OP_FILE_ADDC) & fl.c;
    s   = w + r + cin;
    h   = w[3:0] + r[3:0] + cin;
    case (cmd.op)
      OP_PTR_ADD: ptr[cmd.psel] = ptr[cmd.psel] + {{10{cmd.lit[5]}}, cmd.lit[5:0]};
      OP_IMM_AND: r = w & cmd.lit;
      OP_FILE_AND: r = w & fv;
      OP_SHIFT: r = {fv[7], fv[7:1]};
      OP_BIT_RESET: fv[cmd.idx] = 1'b0;
      OP_IMM_ADD, OP_FILE_ADD, OP_FILE_ADDC: begin
        r  = s[7:0];
        fl = {s[7:0] == 8'h00, h[4], s[8]};
      end
      default: ;
    endcase
    if (cmd.op inside {OP_IMM_AND, OP_FILE_AND, OP_SHIFT}) fl.z = (r == 8'h00);
    if (cmd.op == OP_SHIFT) fl.c = fv[0];
    if (cmd.op inside {OP_IMM_AND, OP_IMM_ADD}) w = r;
    if (cmd.op inside {OP_FILE_AND, OP_FILE_ADD, OP_FILE_ADDC, OP_SHIFT}) begin
      if (cmd.dest) fv = r;
      else w = r;
    end
  endtask : model

  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    rst = 1'b1;
    {awv, wv, bready, arv, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    void'($urandom(32'hb269b325));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    foreach (ptr[i]) rd(OFF_PTR0 + 8'(4 * i), 32'h0, RESP_OKAY);
    rd(OFF_WORK, 32'h0, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'hffff_ffff, RESP_SLVERR);
    // Every op code, including unused ones, with random operands
    for (int k = 0; k < 96; k++) begin
      cmd     = mal_cmd_t'(25'($urandom));
      cmd.op  = mal_op_t'(4'(k % 16));
      w       = 8'($urandom);
      fv      = 8'($urandom);
      fl      = mal_flags_t'(3'($urandom));
      ptr[0]  = near_edge();
      ptr[1]  = near_edge();
      wr(OFF_WORK, {24'h0, w}, RESP_OKAY);
      wr(OFF_PTR0, {16'h0, ptr[0]}, RESP_OKAY);
      wr(OFF_PTR1, {16'h0, ptr[1]}, RESP_OKAY);
      wr(OFF_FADDR, {25'h0, cmd.faddr}, RESP_OKAY);
      wr(OFF_FDATA, {24'h0, fv}, RESP_OKAY);
      wr(OFF_STATUS, {29'h0, fl}, RESP_OKAY);
      wr(OFF_CMD, {7'h0, cmd}, RESP_OKAY);
      model();
      rd(OFF_WORK, {24'h0, w}, RESP_OKAY);
      rd(OFF_STATUS, {29'h0, fl}, RESP_OKAY);
      rd(OFF_PTR0, {16'h0, ptr[0]}, RESP_OKAY);
      rd(OFF_PTR1, {16'h0, ptr[1]}, RESP_OKAY);
      rd(OFF_FDATA, {24'h0, fv}, RESP_OKAY);
    end
    repeat (4) @(posedge clk);
    wrap_up();
  end
endmodule : mal_core_tb
